// File: rtl/single_wire_debug_port.sv
// Notes on behaviour
// - one line pin selects mode at entry and carries all debug traffic.
// - no debug register lives in the processor address space or shares peripherals.
// - a sync command lets the host measure the target's bit rate.
// - memory reads and writes run without halting the user program.
// - cpu register commands act only while halted; sent while running they are dropped.
// - resume restarts the program; single step runs one instruction then halts.
// - while enabled, the halt command wakes the cpu from stop or wait into background.
// - one address breakpoint halts the cpu into background on match.
// - while enabled, the oscillator keeps running in stop mode.
// - the watchdog is held off while the cpu is halted in background.
// - perceived bit start trails the host falling edge by two to three cycles.
// - a returned one gets a short high speedup pulse seven cycles in.
`timescale 1ns/1ps
module single_wire_debug_port (
  // clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  // debug line pin
  input  wire logic                              debug_line_pin_i,
  output logic                                   debug_line_pin_o,
  output logic                                   debug_line_pin_oe_o,
  // cpu run control
  input  wire logic                              cpu_halted_i,
  input  wire logic                              stop_i,
  output logic                                   halt_req_o,
  output logic                                   go_o,
  output logic                                   single_step_cmd_o,
  // breakpoint compare
  input  wire logic                              pc_valid_i,
  input  wire logic [sw_debug_pkg::ADDR_W-1:0]   pc_i,
  // memory access
  output logic                                   mem_req_o,
  output logic                                   mem_we_o,
  output logic [sw_debug_pkg::ADDR_W-1:0]        mem_addr_o,
  output logic [sw_debug_pkg::DATA_W-1:0]        mem_wdata_o,
  input  wire logic                              mem_ack_i,
  input  wire logic [sw_debug_pkg::DATA_W-1:0]   mem_rdata_i,
  // cpu register access
  output logic                                   reg_req_o,
  output logic                                   reg_we_o,
  output logic [sw_debug_pkg::SEL_W-1:0]         reg_sel_o,
  output logic [sw_debug_pkg::DATA_W-1:0]        reg_wdata_o,
  input  wire logic                              reg_ack_i,
  input  wire logic [sw_debug_pkg::DATA_W-1:0]   reg_rdata_i,
  // system hooks
  output logic                                   osc_keep_o,
  output logic                                   watchdog_hold_o
);
  import sw_debug_pkg::*;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic [1:0]  boot;
    bit_state_t  bs;
    logic [7:0]  cnt;
    logic        tx;
    logic        txb;
    logic        rxb;
    logic [2:0]  nbit;
    logic [7:0]  sh;
    logic        bdone;
    logic        pop;
    cmd_state_t  cs;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        ena;
    logic        bken;
    logic [15:0] bkpt;
    logic        line_o;
    logic        line_oe;
    logic        halt;
    logic        go;
    logic        step;
    logic        wdog;
    logic        mreq;
    logic        mwe;
    logic        rreq;
    logic        rwe;
    logic        push;
    logic [7:0]  pdata;
  } st_t;

  localparam st_t ST_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, bs: B_IDLE, cs: C_CMD,
                             ena: ENA_RST, bken: BKEN_RST, bkpt: BKPT_RST,
                             default: '0};

  st_t        q;
  st_t        d;
  logic       fall;
  logic       hit;
  logic       set_halt;
  logic [7:0] b;
  logic       fifo_ir;
  logic       fifo_ov;
  logic [7:0] fifo_od;

  // ==========================================
  // reply buffer
  byte_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_reply (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (q.push),
    .in_data_i   (q.pdata),
    .in_ready_o  (fifo_ir),
    .out_valid_o (fifo_ov),
    .out_data_o  (fifo_od),
    .out_ready_i (q.pop)
  );

  // ==========================================
  // next state
  always_comb begin
    d = q;
    set_halt = 1'b0;
    b = q.sh;
    d.s1 = debug_line_pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    fall = q.s3 & ~q.s2;
    d.bdone = 1'b0;
    d.pop = 1'b0;
    d.go = 1'b0;
    d.step = 1'b0;
    d.wdog = cpu_halted_i;

    // line level just after reset picks the entry mode
    if (q.boot != BOOT_DONE) begin
      d.boot = q.boot + 2'h1;
    end
    if (q.boot == BOOT_CAP && !q.s2) begin
      set_halt = 1'b1;
    end

    // bit engine
    if (q.cnt != CNT_MAX) begin
      d.cnt = q.cnt + 8'h01;
    end
    case (q.bs)
      B_IDLE: begin
      end
      B_BIT: begin
        if (!q.tx && q.cnt == SAMPLE_CYC) begin
          d.rxb = q.s2;
        end
        if (q.cnt == BIT_END_CYC && (q.tx || q.s2)) begin
          d.bs = B_IDLE;
          d.nbit = q.nbit + 3'h1;
          if (q.tx) begin
            d.pop = q.nbit == 3'h7;
          end else begin
            d.sh = {q.sh[6:0], q.rxb};
            d.bdone = q.nbit == 3'h7;
          end
        end else if (!q.tx && q.cnt > BIT_END_CYC && q.s2) begin
          // long low: sync request if long enough, else dropped
          d.bs = (q.cnt >= SYNC_MIN_CYC) ? B_SYWAIT : B_IDLE;
          d.cnt = 8'h00;
          d.nbit = 3'h0;
        end
      end
      B_SYWAIT: begin
        if (q.cnt == SYNC_DLY_CYC) begin
          d.bs = B_SYDRV;
          d.cnt = 8'h00;
        end
      end
      B_SYDRV: begin
        if (q.cnt == SYNC_LOW_CYC - 8'h01) begin
          d.bs = B_IDLE;
        end
      end
      default: d.bs = B_IDLE;
    endcase
    if (fall && q.bs != B_SYDRV) begin
      d.bs = B_BIT;
      d.cnt = 8'h00;
      d.tx = fifo_ov;
      d.txb = fifo_od[3'h7 - q.nbit];
    end

    // line drive: sync pulse, returned zero, or speedup pulse
    if (d.bs == B_SYDRV) begin
      d.line_oe = 1'b1;
      d.line_o = 1'b0;
    end else if (d.bs == B_BIT && d.tx) begin
      d.line_oe = d.txb ? (d.cnt == SPEEDUP_CYC) : (d.cnt < TX0_END_CYC);
      d.line_o = d.txb && (d.cnt == SPEEDUP_CYC);
    end else begin
      d.line_oe = 1'b0;
      d.line_o = 1'b0;
    end

    // command engine; its control bits are internal only
    case (q.cs)
      C_CMD: begin
        if (q.bdone) begin
          d.cmd = b;
          if (b == CMD_HALT) begin
            set_halt = q.ena;
          end else if (b == CMD_GO) begin
            d.go = cpu_halted_i;
          end else if (b == CMD_STEP) begin
            d.step = cpu_halted_i;
          end else if (b == CMD_RD_STAT) begin
            d.pdata = {q.ena, q.bken, cpu_halted_i, stop_i, 4'h0};
            d.cs = C_PUSH;
          end else if (b == CMD_WR_CTRL) begin
            d.cs = C_DATA;
          end else if (grp_match(b, CMD_RD_REG)) begin
            d.cs = cpu_halted_i ? C_REG : C_CMD;
          end else if (grp_match(b, CMD_WR_REG)) begin
            d.cs = cpu_halted_i ? C_DATA : C_CMD;
          end else if (b == CMD_RD_MEM || b == CMD_WR_MEM || b == CMD_WR_BKPT) begin
            d.cs = C_AHI;
          end
        end
      end
      C_AHI: begin
        if (q.bdone) begin
          d.addr[15:8] = b;
          d.cs = C_ALO;
        end
      end
      C_ALO: begin
        if (q.bdone) begin
          d.addr[7:0] = b;
          if (q.cmd == CMD_RD_MEM) begin
            d.cs = C_MEM;
          end else if (q.cmd == CMD_WR_MEM) begin
            d.cs = C_DATA;
          end else begin
            d.bkpt = {q.addr[15:8], b};
            d.cs = C_CMD;
          end
        end
      end
      C_DATA: begin
        if (q.bdone) begin
          d.data = b;
          if (q.cmd == CMD_WR_CTRL) begin
            d.ena = b[CTRL_ENA_BIT];
            d.bken = b[CTRL_BKEN_BIT];
            d.cs = C_CMD;
          end else begin
            d.cs = (q.cmd == CMD_WR_MEM) ? C_MEM : C_REG;
          end
        end
      end
      C_MEM: begin
        d.mreq = 1'b1;
        d.mwe = q.cmd == CMD_WR_MEM;
        if (q.mreq && mem_ack_i) begin
          d.mreq = 1'b0;
          d.pdata = mem_rdata_i;
          d.cs = q.mwe ? C_CMD : C_PUSH;
        end
      end
      C_REG: begin
        d.rreq = cpu_halted_i;
        d.rwe = grp_match(q.cmd, CMD_WR_REG);
        if ((q.rreq && reg_ack_i) || !cpu_halted_i) begin
          d.rreq = 1'b0;
          d.pdata = reg_rdata_i;
          d.cs = (q.rwe || !cpu_halted_i) ? C_CMD : C_PUSH;
        end
      end
      C_PUSH: begin
        d.push = 1'b1;
        if (q.push && fifo_ir) begin
          d.push = 1'b0;
          d.cs = C_CMD;
        end
      end
      default: d.cs = C_CMD;
    endcase

    // halt request: held until the cpu reports halted, a new cause wins
    hit = q.bken && pc_valid_i && pc_i == q.bkpt && !cpu_halted_i;
    if (q.halt && cpu_halted_i) begin
      d.halt = 1'b0;
    end
    if (set_halt || hit) begin
      d.halt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // outputs
  assign debug_line_pin_o    = q.line_o;
  assign debug_line_pin_oe_o = q.line_oe;
  assign halt_req_o          = q.halt;
  assign go_o                = q.go;
  assign single_step_cmd_o   = q.step;
  assign mem_req_o           = q.mreq;
  assign mem_we_o            = q.mwe;
  assign mem_addr_o          = q.addr;
  assign mem_wdata_o         = q.data;
  assign reg_req_o           = q.rreq;
  assign reg_we_o            = q.rwe;
  assign reg_sel_o           = q.cmd[2:0];
  assign reg_wdata_o         = q.data;
  assign osc_keep_o          = q.ena;
  assign watchdog_hold_o     = q.wdog;

  // ==========================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_speedup_pulse: assert property (
    (q.bs == B_BIT && q.tx && q.txb && q.cnt == SPEEDUP_CYC) |->
      (debug_line_pin_oe_o && debug_line_pin_o))
    else $error("speedup pulse missing at cycle seven");
  a_speedup_short: assert property (
    $rose(debug_line_pin_o) |=> !debug_line_pin_o)
    else $error("speedup pulse longer than one cycle");
  a_bit_restart: assert property (
    (fall && q.bs != B_SYDRV) |=> (q.bs == B_BIT && q.cnt == 8'h00))
    else $error("bit counter not restarted on falling edge");
  a_reg_when_halted: assert property (
    $rose(reg_req_o) |-> $past(cpu_halted_i))
    else $error("register access while cpu running");
  a_step_halted: assert property (
    (single_step_cmd_o || go_o) |-> $past(cpu_halted_i))
    else $error("run control issued while not halted");
  a_halt_wake: assert property (
    (q.cs == C_CMD && q.bdone && q.sh == CMD_HALT && q.ena && !cpu_halted_i) |=> halt_req_o)
    else $error("halt command did not raise halt request");
  a_bkpt_halt: assert property (
    (q.bken && pc_valid_i && pc_i == q.bkpt && !cpu_halted_i) |=> halt_req_o)
    else $error("breakpoint match did not halt");
  a_wdog_hold: assert property (
    cpu_halted_i [*2] |-> watchdog_hold_o)
    else $error("watchdog not held while halted");
  a_sync_low: assert property (
    $rose(q.bs == B_SYDRV) |-> (debug_line_pin_oe_o && !debug_line_pin_o) [*8])
    else $error("sync reply pulse not driven low");

  c_tx_one:   cover property (q.bs == B_BIT && q.tx && q.txb && q.cnt == SPEEDUP_CYC);
  c_sync:     cover property ($rose(q.bs == B_SYDRV));
  c_mem_read: cover property (q.cs == C_MEM && q.mreq && mem_ack_i && !q.mwe);
  c_step:     cover property (single_step_cmd_o);
endmodule

// File: rtl/sw_debug_pkg.sv
package sw_debug_pkg;
  // ==========================================
  // widths and buffering
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEL_W  = 3;
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 16;

  // ==========================================
  // bit timing, in debug clock cycles
  localparam logic [7:0] SPEEDUP_CYC  = 8'h07;
  localparam logic [7:0] SAMPLE_CYC   = 8'h0A;
  localparam logic [7:0] TX0_END_CYC  = 8'h0D;
  localparam logic [7:0] BIT_END_CYC  = 8'h10;
  localparam logic [7:0] SYNC_MIN_CYC = 8'h80;
  localparam logic [7:0] SYNC_DLY_CYC = 8'h10;
  localparam logic [7:0] SYNC_LOW_CYC = 8'h80;
  localparam logic [7:0] CNT_MAX      = 8'hFF;
  localparam logic [1:0] BOOT_CAP     = 2'h2;
  localparam logic [1:0] BOOT_DONE    = 2'h3;

  // ==========================================
  // commands
  localparam logic [7:0] CMD_HALT    = 8'h90;
  localparam logic [7:0] CMD_GO      = 8'h08;
  localparam logic [7:0] CMD_STEP    = 8'h10;
  localparam logic [7:0] CMD_RD_STAT = 8'hE4;
  localparam logic [7:0] CMD_WR_CTRL = 8'hC4;
  localparam logic [7:0] CMD_RD_MEM  = 8'hE0;
  localparam logic [7:0] CMD_WR_MEM  = 8'hC0;
  localparam logic [7:0] CMD_WR_BKPT = 8'hC2;
  localparam logic [7:0] CMD_RD_REG  = 8'h68;
  localparam logic [7:0] CMD_WR_REG  = 8'h48;

  // ==========================================
  // control byte fields and reset values
  localparam int unsigned CTRL_ENA_BIT  = 7;
  localparam int unsigned CTRL_BKEN_BIT = 6;
  localparam logic        ENA_RST       = 1'b0;
  localparam logic        BKEN_RST      = 1'b0;
  localparam logic [15:0] BKPT_RST      = 16'h0000;

  typedef enum logic [3:0] {
    B_IDLE   = 4'b0001,
    B_BIT    = 4'b0010,
    B_SYWAIT = 4'b0100,
    B_SYDRV  = 4'b1000
  } bit_state_t;

  typedef enum logic [6:0] {
    C_CMD  = 7'h01,
    C_AHI  = 7'h02,
    C_ALO  = 7'h04,
    C_DATA = 7'h08,
    C_MEM  = 7'h10,
    C_REG  = 7'h20,
    C_PUSH = 7'h40
  } cmd_state_t;

  // register commands carry the register select in the low three bits
  function automatic logic grp_match(input logic [7:0] c, input logic [7:0] base);
    return c[7:3] == base[7:3];
  endfunction
endpackage

// File: rtl/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = sw_debug_pkg::FIFO_W,
  parameter int unsigned DEPTH = sw_debug_pkg::FIFO_D
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  import sw_debug_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } fifo_st_t;

  fifo_st_t q;
  fifo_st_t d;
  logic     full;
  logic     empty;

  assign full  = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
  assign empty = q.wp == q.rp;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = q.mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid_i && !full) begin
      d.mem[q.wp[AW-1:0]] = in_data_i;
      d.wp = q.wp + (AW+1)'(1);
    end
    if (out_ready_i && !empty) begin
      d.rp = q.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// File: sim/debug_host_model.sv
`timescale 1ns/1ps
module debug_host_model (
  // clock
  input  wire logic clk_i,
  // open debug line
  input  wire logic line_i,
  output logic      pull_low_o
);
  // ==========================================
  // bit slot timing, in debug clocks
  localparam int BIT_PERIOD = 24;
  localparam int HOLD_ONE   = 4;
  localparam int HOLD_ZERO  = 13;
  localparam int HOLD_RX    = 3;
  localparam int SAMPLE_AT  = 12;

  initial pull_low_o = 1'b0;

  // ==========================================
  // host-to-target bits
  task automatic send_bit(input logic b);
    int i;
    @(negedge clk_i);
    pull_low_o = 1'b1;
    for (i = 0; i < BIT_PERIOD; i++) begin
      if (i == (b ? HOLD_ONE : HOLD_ZERO)) pull_low_o = 1'b0;
      @(negedge clk_i);
    end
  endtask

  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) send_bit(v[i]);
  endtask

  // ==========================================
  // target-to-host bits
  task automatic recv_bit(output logic b);
    int i;
    b = 1'b0;
    @(negedge clk_i);
    pull_low_o = 1'b1;
    for (i = 0; i < BIT_PERIOD; i++) begin
      if (i == HOLD_RX) pull_low_o = 1'b0;
      if (i == SAMPLE_AT) b = line_i;
      @(negedge clk_i);
    end
  endtask

  task automatic recv_byte(output logic [7:0] v);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      recv_bit(b);
      v[i] = b;
    end
  endtask

  // ==========================================
  // rate discovery: long low, then time the reply
  task automatic sync(output int low_len);
    low_len = 0;
    @(negedge clk_i);
    pull_low_o = 1'b1;
    repeat (140) @(negedge clk_i);
    pull_low_o = 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_i);
      if (!line_i) low_len++;
      else if (low_len > 0) break;
    end
  endtask
endmodule

// File: sim/single_wire_debug_port_tb.sv
`timescale 1ns/1ps
module single_wire_debug_port_tb;
  import sw_debug_pkg::*;
  // ==========================================
  // signals
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        pull, line, line_do, line_oe;
  logic        cpu_halted = 1'b0;
  logic        stop       = 1'b0;
  logic        halt_req, go, step, osc_keep, wd_hold;
  logic        pc_valid   = 1'b0;
  logic [15:0] pc         = 16'h0000;
  logic        mem_req, mem_we, reg_req, reg_we;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, reg_wdata;
  logic [2:0]  reg_sel;
  logic        mem_ack   = 1'b0;
  logic        reg_ack   = 1'b0;
  logic [7:0]  mem_rdata = 8'h00;
  logic [7:0]  reg_rdata = 8'h00;
  logic [7:0]  mem [0:65535];
  logic [7:0]  regs [0:7];
  int          errors = 0, samples_checked = 0;
  int          go_cnt = 0, step_cnt = 0, reg_reqs = 0, pulses = 0, pulse_ofs = 0, ofs = 0;
  logic        pull_q = 1'b0;
  logic        strap  = 1'b0;

  always #12.5 clk_i = ~clk_i;

  // open line with pull-up
  assign line = line_oe ? line_do : !(pull || strap);

  single_wire_debug_port dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .debug_line_pin_i(line), .debug_line_pin_o(line_do), .debug_line_pin_oe_o(line_oe),
    .cpu_halted_i(cpu_halted), .stop_i(stop), .halt_req_o(halt_req), .go_o(go),
    .single_step_cmd_o(step), .pc_valid_i(pc_valid), .pc_i(pc),
    .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
    .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
    .reg_req_o(reg_req), .reg_we_o(reg_we), .reg_sel_o(reg_sel), .reg_wdata_o(reg_wdata),
    .reg_ack_i(reg_ack), .reg_rdata_i(reg_rdata),
    .osc_keep_o(osc_keep), .watchdog_hold_o(wd_hold)
  );

  debug_host_model host (.clk_i(clk_i), .line_i(line), .pull_low_o(pull));

  // ==========================================
  // memory, cpu registers and run state
  always @(negedge clk_i) begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_req === 1'b1 && !mem_ack) begin
      mem_rdata <= mem[mem_addr];
      if (mem_we) mem[mem_addr] <= mem_wdata;
    end
    reg_ack <= reg_req && !reg_ack;
    if (reg_req === 1'b1 && !reg_ack) begin
      reg_rdata <= regs[reg_sel];
      if (reg_we) regs[reg_sel] <= reg_wdata;
      reg_reqs++;
    end
    if (go === 1'b1) go_cnt++;
    if (step === 1'b1) step_cnt++;
    if (halt_req === 1'b1) cpu_halted <= 1'b1;
    else if (go === 1'b1) cpu_halted <= 1'b0;
  end

  // speedup pulse position relative to the host's fall
  always @(posedge clk_i) begin
    if (pull && !pull_q) ofs = 0;
    else ofs++;
    pull_q <= pull;
  end

  // outputs are looked at half a cycle after the edge that launches them
  always @(negedge clk_i) begin
    if (line_oe === 1'b1 && line_do === 1'b1) begin
      pulses++;
      pulse_ofs = ofs;
    end
  end

  // ==========================================
  // compare and report
  task automatic fail(input string what);
    errors++;
    $display("unexpected at %0t: %s", $time, what);
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) fail(what);
  endtask

  task automatic check_flag(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) fail(what);
  endtask

  task automatic check_cnt(input int got, input int lo, input int hi, input string what);
    samples_checked++;
    if (got < lo || got > hi) fail(what);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b);
    host.send_byte(b);
  endtask

  task automatic get_reply(input logic [7:0] exp, input string what);
    logic [7:0] v;
    int         p0;
    repeat (200) @(negedge clk_i);
    p0 = pulses;
    host.recv_byte(v);
    check8(v, exp, what);
    check_cnt(pulses - p0, $countones(exp), $countones(exp), "speedup count");
    if (exp != 8'h00) check_cnt(pulse_ofs, 9, 12, "speedup position");
  endtask

  task automatic wait_halt();
    int i;
    for (i = 0; i < 300 && cpu_halted !== 1'b1; i++) @(negedge clk_i);
    if (cpu_halted !== 1'b1) begin
      fail("halt wait ran out");
      complete_run();
    end
  endtask

  // ==========================================
  // scenarios
  task automatic test_sync();
    int len;
    host.sync(len);
    check_cnt(len, int'(SYNC_LOW_CYC), int'(SYNC_LOW_CYC), "sync reply length");
    $display("test_sync done");
  endtask

  task automatic test_ctrl();
    check_flag(osc_keep, ENA_RST, "oscillator keep at reset");
    send(CMD_WR_CTRL);
    send(8'hC0);
    send(CMD_RD_STAT);
    get_reply(8'hC0, "status while running");
    check_flag(osc_keep, 1'b1, "oscillator keep when enabled");
    $display("test_ctrl done");
  endtask

  task automatic test_mem();
    send(CMD_WR_MEM); send(8'h12); send(8'h34); send(8'hA5);
    send(CMD_RD_MEM); send(8'h12); send(8'h34);
    get_reply(8'hA5, "memory read back");
    check8(mem[16'h1234], 8'hA5, "memory written");
    check_flag(halt_req, 1'b0, "no halt for memory access");
    send(CMD_RD_REG | 8'h03);
    repeat (200) @(negedge clk_i);
    check_cnt(reg_reqs, 0, 0, "register access while running");
    $display("test_mem done");
  endtask

  task automatic test_halt();
    stop = 1'b1;
    send(CMD_HALT);
    wait_halt();
    repeat (3) @(negedge clk_i);
    check_flag(wd_hold, 1'b1, "watchdog held in background");
    check_flag(halt_req, 1'b0, "halt request cleared");
    send(CMD_RD_STAT);
    get_reply(8'hF0, "status while halted in stop");
    stop = 1'b0;
    // register commands only while halted
    send(CMD_RD_REG | 8'h03);
    get_reply(8'h5A, "register read");
    send(CMD_WR_REG | 8'h05); send(8'h3C);
    repeat (200) @(negedge clk_i);
    check8(regs[5], 8'h3C, "register written");
    $display("test_halt done");
  endtask

  task automatic test_run();
    send(CMD_STEP);
    repeat (30) @(negedge clk_i);
    check_cnt(step_cnt, 1, 1, "single step pulses");
    check_cnt(go_cnt, 0, 0, "no resume on step");
    send(CMD_GO);
    repeat (30) @(negedge clk_i);
    check_cnt(go_cnt, 1, 1, "resume pulses");
    check_flag(wd_hold, 1'b0, "watchdog free when running");
    $display("test_run done");
  endtask

  task automatic test_bkpt();
    send(CMD_WR_BKPT); send(8'h04); send(8'h56);
    repeat (30) @(negedge clk_i);
    pc_valid = 1'b1;
    pc = 16'h0455;
    repeat (8) @(negedge clk_i);
    check_flag(halt_req, 1'b0, "no halt off breakpoint");
    pc = 16'h0456;
    @(negedge clk_i);
    pc_valid = 1'b0;
    wait_halt();
    $display("test_bkpt done");
  endtask

  task automatic test_boot();
    send(CMD_GO);
    repeat (30) @(negedge clk_i);
    check_cnt(go_cnt, 2, 2, "resume before strap");
    rst_n_i = 1'b0;
    strap   = 1'b1;
    repeat (8) @(negedge clk_i);
    check_flag(halt_req, 1'b0, "halt request low in reset");
    check_flag(osc_keep, ENA_RST, "enable cleared by reset");
    rst_n_i = 1'b1;
    repeat (40) @(negedge clk_i);
    strap = 1'b0;
    wait_halt();
    repeat (20) @(negedge clk_i);
    check_flag(halt_req, 1'b0, "strap halt request cleared");
    send(CMD_RD_STAT);
    get_reply(8'h20, "status after strap entry");
    $display("test_boot done");
  endtask

  // ==========================================
  // main sequence and hang guard
  initial begin
    regs[3] = 8'h5A;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    test_sync();
    test_ctrl();
    test_mem();
    test_halt();
    test_run();
    test_bkpt();
    test_boot();
    complete_run();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    fail("run limit reached");
    complete_run();
  end
endmodule
